// >>> nand_host_cfg.svh
// Constants for the NAND host controller
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH
`define CMD_RESET        8'hFF
`define CMD_READ_SETUP   8'h00
`define CMD_READ_CONFIRM 8'h30
`define CMD_PROG_SETUP   8'h80
`define CMD_PROG_CONFIRM 8'h10
`define CMD_ERASE_SETUP  8'h60
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_STATUS       8'h70
`define CMD_SET_FEAT     8'hEF
`define CMD_CACHE_PROG   8'h15
`define FEAT_ECC_ADDR    8'h90
`define FEAT_ECC_ON      8'h08
`define PAGE_MAIN_BYTES  12'd2048
`define PAGE_SPARE_BYTES 12'd64
`define PAGE_BYTES       12'd2112
`define PAGE_MAIN_WORDS  12'd1024
`define PAGE_WORDS       12'd1056
`define PAGES_PER_BLOCK  7'd64
`define BLOCKS_PER_PLANE 13'd2048
`define BLOCKS_4GB       14'd4096
`define BLOCKS_8GB       14'd8192
`define PLANE_BIT        6
`define CLK_PERIOD_NS    4
`define STROBE_NS        25
`define STROBE_CYC       ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_US          200
`define ERASE_US         700
`define PROG_CYC         ((`PROG_US * 1000) / `CLK_PERIOD_NS)
`define ERASE_CYC        ((`ERASE_US * 1000) / `CLK_PERIOD_NS)
`define STS_FAIL_BIT     0
`define STS_READY_BIT    6
`define STS_WP_N_BIT     7
`define FIFO_DEPTH       8
`endif

// >>> nand_host_pkg.sv
// Types for the NAND host controller
package nand_host_pkg;
   typedef enum logic [9:0] {
      ST_IDLE   = 10'b00_0000_0001,
      ST_CMD1   = 10'b00_0000_0010,
      ST_ADDR   = 10'b00_0000_0100,
      ST_WDATA  = 10'b00_0000_1000,
      ST_CMD2   = 10'b00_0001_0000,
      ST_BUSY   = 10'b00_0010_0000,
      ST_STCMD  = 10'b00_0100_0000,
      ST_RDATA  = 10'b00_1000_0000,
      ST_FEAT   = 10'b01_0000_0000,
      ST_DONE   = 10'b10_0000_0000
   } state_type;
   typedef enum logic [2:0] {
      OP_RESET  = 3'h0,
      OP_READ   = 3'h1,
      OP_PROG   = 3'h2,
      OP_ERASE  = 3'h3,
      OP_STATUS = 3'h4,
      OP_ECC    = 3'h5,
      OP_CPROG  = 3'h6
   } op_type;
endpackage

// >>> data_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
module data_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clock,
   input  wire logic             i_rst_n,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign o_out_data  = mem_r[rd_ptr_r];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_ff @(posedge i_clock) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// >>> nand_host.sv
// Host controller driving a NAND die over its strobe pins
// Summary of operation
// - Eight-bit shared bus with two strobes (write and read)
// - Five address cycles (three row cycles for erase), unused bits low
// - Column bit 11 clears bits 10:6
// - Reset command first after power-on
// - Command on CLE, address on ALE
`include "nand_host_cfg.svh"
module nand_host #(
   parameter int PROG_TIMEOUT  = `PROG_CYC * 4,
   parameter int ERASE_TIMEOUT = `ERASE_CYC * 4
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic        i_req,
   input  wire logic [2:0]  i_op,
   input  wire logic [11:0] i_column,
   input  wire logic [5:0]  i_page,
   input  wire logic [12:0] i_block,
   input  wire logic        i_big_die,
   input  wire logic        i_wide,
   input  wire logic        i_wp_allow,
   input  wire logic [11:0] i_len,
   input  wire logic        i_wr_valid,
   output logic             o_wr_ready,
   input  wire logic [7:0]  i_wr_data,
   output logic             o_rd_valid,
   output logic      [7:0]  o_rd_data,
   output logic             o_ack,
   output logic             o_busy,
   output logic             o_err,
   output logic      [7:0]  o_status,
   output logic             o_ecc_on,
   output logic             o_ce_n,
   output logic             o_cle,
   output logic             o_ale,
   output logic             o_write_strobe_n,
   output logic             o_read_strobe_n,
   output logic             o_wp_n,
   output logic      [7:0]  o_io_out,
   output logic             o_io_oe_n,
   input  wire logic [7:0]  i_io_in,
   input  wire logic        i_ready_busy_n
);
   localparam logic [7:0] STROBE_CYC = 8'(`STROBE_CYC);
   localparam int         TW = 20;

   nand_host_pkg::state_type state_r;
   nand_host_pkg::op_type    op_r;
   logic [39:0] addr_r;
   logic [2:0]  acnt_r;
   logic [2:0]  ncyc_r;
   logic [11:0] dcnt_r;
   logic [7:0]  tick_r;
   logic        phase_r;
   logic [TW-1:0] wait_r;
   logic        init_done_r;
   logic        ecc_r;
   logic        fifo_valid;
   logic        fifo_pop;
   logic [7:0]  fifo_data;
   logic        strobe_end;
   logic        sample_pt;

   // Address cycles and field packing
   function automatic logic [39:0] pack_addr(input logic [11:0] col, input logic [5:0] pg,
                                             input logic [12:0] blk, input logic big);
      logic [11:0] c;
      logic [18:0] row;
      c = col;
      if (c[11]) c[10:6] = 5'h00;
      row = {(big ? blk : {1'b0, blk[11:0]}), pg};
      pack_addr = {5'h00, row[18:16], row[15:8], row[7:0], 4'h0, c[11:8], c[7:0]};
   endfunction

   function automatic logic plane_of(input logic [18:0] row);
      plane_of = row[`PLANE_BIT];
   endfunction

   // one byte per write strobe from the FIFO
   data_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .i_clock     (i_clock),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (i_wr_valid),
      .o_in_ready  (o_wr_ready),
      .i_in_data   (i_wr_data),
      .o_out_valid (fifo_valid),
      .i_out_ready (fifo_pop),
      .o_out_data  (fifo_data)
   );

   assign strobe_end = phase_r && (tick_r == STROBE_CYC);
   // Read data is taken at the last low cycle of the read strobe
   assign sample_pt  = !phase_r && (tick_r == STROBE_CYC);
   assign fifo_pop   = (state_r == nand_host_pkg::ST_WDATA) && strobe_end;
   assign o_ecc_on   = ecc_r;
   assign o_wp_n     = i_wp_allow;

   // Strobe timing: low half then high half
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_r  <= 8'h00;
         phase_r <= 1'b0;
      end else if (state_r inside {nand_host_pkg::ST_CMD1, nand_host_pkg::ST_ADDR, nand_host_pkg::ST_CMD2,
                                   nand_host_pkg::ST_STCMD, nand_host_pkg::ST_RDATA, nand_host_pkg::ST_FEAT}
                   || (state_r == nand_host_pkg::ST_WDATA && fifo_valid)) begin
         if (tick_r == STROBE_CYC) begin
            tick_r  <= 8'h01;
            phase_r <= !phase_r;
         end else begin
            tick_r <= tick_r + 8'h01;
         end
      end else begin
         tick_r  <= 8'h00;
         phase_r <= 1'b0;
      end
   end

   // Main sequencer
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r     <= nand_host_pkg::ST_IDLE;
         op_r        <= nand_host_pkg::OP_RESET;
         addr_r      <= '0;
         acnt_r      <= 3'h0;
         ncyc_r      <= 3'h0;
         dcnt_r      <= 12'h000;
         wait_r      <= '0;
         init_done_r <= 1'b0;
         ecc_r       <= 1'b0;
         o_ack       <= 1'b0;
         o_err       <= 1'b0;
         o_status    <= 8'h00;
         o_rd_valid  <= 1'b0;
         o_rd_data   <= 8'h00;
      end else begin
         o_ack      <= 1'b0;
         o_rd_valid <= 1'b0;
         unique case (state_r)
            nand_host_pkg::ST_IDLE: begin
               if (i_req) begin
                  op_r   <= nand_host_pkg::op_type'(i_op);
                  addr_r <= pack_addr(i_column, i_page, i_block, i_big_die);
                  acnt_r <= 3'h0;
                  dcnt_r <= 12'h000;
                  o_err  <= 1'b0;
                  if (!init_done_r && i_op != 3'(nand_host_pkg::OP_RESET)) begin
                     o_err <= 1'b1;
                     o_ack <= 1'b1;
                  end else if (i_op == 3'(nand_host_pkg::OP_CPROG) && ecc_r) begin
                     o_err <= 1'b1;
                     o_ack <= 1'b1;
                  end else if (i_len > (i_wide ? `PAGE_WORDS : `PAGE_BYTES)) begin
                     o_err <= 1'b1;
                     o_ack <= 1'b1;
                  end else begin
                     ncyc_r  <= (i_op == 3'(nand_host_pkg::OP_ERASE)) ? 3'd3 : 3'd5;
                     state_r <= nand_host_pkg::ST_CMD1;
                  end
               end
            end
            nand_host_pkg::ST_CMD1: begin
               if (strobe_end) begin
                  unique case (op_r)
                     nand_host_pkg::OP_RESET, nand_host_pkg::OP_STATUS:
                        state_r <= nand_host_pkg::ST_BUSY;
                     nand_host_pkg::OP_ECC:
                        state_r <= nand_host_pkg::ST_FEAT;
                     nand_host_pkg::OP_ERASE: begin
                        addr_r  <= {16'h0000, addr_r[39:16]};
                        state_r <= nand_host_pkg::ST_ADDR;
                     end
                     default: state_r <= nand_host_pkg::ST_ADDR;
                  endcase
                  wait_r <= '0;
               end
            end
            nand_host_pkg::ST_ADDR: begin
               if (strobe_end) begin
                  addr_r <= {8'h00, addr_r[39:8]};
                  acnt_r <= acnt_r + 3'h1;
                  if (acnt_r + 3'h1 == ncyc_r) begin
                     state_r <= (op_r inside {nand_host_pkg::OP_PROG, nand_host_pkg::OP_CPROG})
                              ? nand_host_pkg::ST_WDATA : nand_host_pkg::ST_CMD2;
                  end
               end
            end
            nand_host_pkg::ST_FEAT: begin
               if (strobe_end) begin
                  acnt_r <= acnt_r + 3'h1;
                  if (acnt_r == 3'h4) begin
                     ecc_r   <= 1'b1;
                     o_ack   <= 1'b1;
                     state_r <= nand_host_pkg::ST_IDLE;
                  end
               end
            end
            nand_host_pkg::ST_WDATA: begin
               if (fifo_pop) begin
                  dcnt_r <= dcnt_r + 12'h001;
                  if (dcnt_r + 12'h001 == i_len) begin
                     state_r <= nand_host_pkg::ST_CMD2;
                  end
               end
            end
            nand_host_pkg::ST_CMD2: begin
               if (strobe_end) begin
                  wait_r  <= '0;
                  state_r <= nand_host_pkg::ST_BUSY;
               end
            end
            nand_host_pkg::ST_BUSY: begin
               wait_r <= wait_r + TW'(1);
               if (wait_r > TW'(4) && i_ready_busy_n) begin
                  state_r <= nand_host_pkg::ST_STCMD;
                  if (op_r == nand_host_pkg::OP_RESET) init_done_r <= 1'b1;
               end else if (wait_r == TW'((op_r == nand_host_pkg::OP_ERASE) ? ERASE_TIMEOUT : PROG_TIMEOUT)) begin
                  o_err   <= 1'b1;
                  o_ack   <= 1'b1;
                  state_r <= nand_host_pkg::ST_IDLE;
               end
            end
            nand_host_pkg::ST_STCMD: begin
               if (strobe_end) begin
                  dcnt_r  <= 12'h000;
                  state_r <= nand_host_pkg::ST_RDATA;
               end
            end
            nand_host_pkg::ST_RDATA: begin
               if (sample_pt) begin
                  if (dcnt_r == 12'h000) begin
                     o_status <= i_io_in;
                     if (!i_io_in[`STS_READY_BIT] || i_io_in[`STS_FAIL_BIT]) o_err <= 1'b1;
                     if (op_r inside {nand_host_pkg::OP_PROG, nand_host_pkg::OP_ERASE}
                         && !i_io_in[`STS_WP_N_BIT]) o_err <= 1'b1;
                  end
                  if (op_r == nand_host_pkg::OP_READ && dcnt_r != 12'h000) begin
                     o_rd_data  <= i_io_in;
                     o_rd_valid <= 1'b1;
                  end
               end
               if (strobe_end) begin
                  dcnt_r <= dcnt_r + 12'h001;
                  if (op_r != nand_host_pkg::OP_READ || dcnt_r == i_len) begin
                     state_r <= nand_host_pkg::ST_DONE;
                  end
               end
            end
            nand_host_pkg::ST_DONE: begin
               o_ack   <= 1'b1;
               state_r <= nand_host_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // pin drive from state and phase
   // CLE for commands, ALE for addresses
   always_comb begin
      o_ce_n           = (state_r == nand_host_pkg::ST_IDLE) || (state_r == nand_host_pkg::ST_DONE);
      o_cle            = state_r inside {nand_host_pkg::ST_CMD1, nand_host_pkg::ST_CMD2, nand_host_pkg::ST_STCMD};
      o_ale            = (state_r == nand_host_pkg::ST_ADDR)
                      || (state_r == nand_host_pkg::ST_FEAT && acnt_r == 3'h0);
      o_write_strobe_n = !(!phase_r && tick_r != 8'h00 && state_r != nand_host_pkg::ST_RDATA
                           && (state_r != nand_host_pkg::ST_WDATA || fifo_valid)
                           && (o_cle || state_r inside {nand_host_pkg::ST_ADDR, nand_host_pkg::ST_WDATA,
                                                        nand_host_pkg::ST_FEAT}));
      o_read_strobe_n  = !(!phase_r && tick_r != 8'h00 && state_r == nand_host_pkg::ST_RDATA);
      o_io_oe_n        = (state_r == nand_host_pkg::ST_RDATA) || o_ce_n || (state_r == nand_host_pkg::ST_BUSY);
      o_io_out         = 8'h00;
      unique case (state_r)
         nand_host_pkg::ST_CMD1: begin
            unique case (op_r)
               nand_host_pkg::OP_RESET:  o_io_out = `CMD_RESET;
               nand_host_pkg::OP_READ:   o_io_out = `CMD_READ_SETUP;
               nand_host_pkg::OP_ERASE:  o_io_out = `CMD_ERASE_SETUP;
               nand_host_pkg::OP_STATUS: o_io_out = `CMD_STATUS;
               nand_host_pkg::OP_ECC:    o_io_out = `CMD_SET_FEAT;
               default:                  o_io_out = `CMD_PROG_SETUP;
            endcase
         end
         nand_host_pkg::ST_ADDR:  o_io_out = addr_r[7:0];
         nand_host_pkg::ST_FEAT:  o_io_out = (acnt_r == 3'h0) ? `FEAT_ECC_ADDR
                                           : (acnt_r == 3'h1) ? `FEAT_ECC_ON : 8'h00;
         nand_host_pkg::ST_WDATA: o_io_out = fifo_data;
         nand_host_pkg::ST_CMD2: begin
            unique case (op_r)
               nand_host_pkg::OP_READ:   o_io_out = `CMD_READ_CONFIRM;
               nand_host_pkg::OP_ERASE:  o_io_out = `CMD_ERASE_CONFIRM;
               nand_host_pkg::OP_CPROG:  o_io_out = `CMD_CACHE_PROG;
               default:                  o_io_out = `CMD_PROG_CONFIRM;
            endcase
         end
         nand_host_pkg::ST_STCMD: o_io_out = `CMD_STATUS;
         default:                 o_io_out = 8'h00;
      endcase
   end

   // busy while the pin is pulled low or the sequencer is not idle
   assign o_busy = !i_ready_busy_n || (state_r != nand_host_pkg::ST_IDLE);
endmodule

// >>> nand_host_chk_props.sv
// Checker for the NAND host pin protocol
module nand_host_chk (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_req,
   input wire logic i_wp_allow,
   input wire logic i_ready_busy_n,
   input wire logic o_ack,
   input wire logic o_busy,
   input wire logic o_err,
   input wire logic o_ce_n,
   input wire logic o_cle,
   input wire logic o_ale,
   input wire logic o_write_strobe_n,
   input wire logic o_read_strobe_n,
   input wire logic o_wp_n,
   input wire logic o_io_oe_n
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   chk_wp_follow: assert property (o_wp_n == i_wp_allow)
      else $error("wp pin mismatch");
   chk_latch_excl: assert property (!(o_cle && o_ale))
      else $error("cmd and addr latch together");
   chk_strobe_sel: assert property (!o_write_strobe_n || !o_read_strobe_n |-> !o_ce_n)
      else $error("strobe without select");
   chk_write_drive: assert property (!o_write_strobe_n |-> !o_io_oe_n)
      else $error("write strobe with bus released");
   chk_read_release: assert property (!o_read_strobe_n |-> o_io_oe_n && !o_cle && !o_ale)
      else $error("read strobe with bus driven");
   chk_we_width: assert property ($fell(o_write_strobe_n) |-> !o_write_strobe_n [*7] ##1 o_write_strobe_n)
      else $error("write strobe width");
   chk_re_high: assert property ($rose(o_read_strobe_n) |-> o_read_strobe_n [*7])
      else $error("read strobe high time");
   chk_busy_pin: assert property (!i_ready_busy_n |-> o_write_strobe_n && o_read_strobe_n)
      else $error("strobe while pin busy");
   chk_req_taken: assert property (i_req && !o_busy && i_ready_busy_n |-> ##[1:2] (o_busy || o_ack))
      else $error("request not taken");
   chk_ack_pulse: assert property (o_ack |=> !o_ack)
      else $error("ack longer than one cycle");
   chk_err_ack: assert property ($rose(o_err) |-> ##[0:15] o_ack)
      else $error("error without ack");
   cover property ($rose(o_err));
   cover property (!i_ready_busy_n ##1 i_ready_busy_n);
   cover property ($fell(o_read_strobe_n));
endmodule
bind nand_host nand_host_chk u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(i_req),
   .i_wp_allow(i_wp_allow), .i_ready_busy_n(i_ready_busy_n), .o_ack(o_ack), .o_busy(o_busy),
   .o_err(o_err), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale), .o_write_strobe_n(o_write_strobe_n),
   .o_read_strobe_n(o_read_strobe_n), .o_wp_n(o_wp_n), .o_io_oe_n(o_io_oe_n));

// >>> nand_die_model.sv
// Behavioural NAND die answering the host pins
module nand_die_model #(
   parameter int PROG_BUSY  = 40,
   parameter int ERASE_BUSY = 60,
   parameter int SHORT_BUSY = 12
) (
   input  wire logic        i_clock,
   input  wire logic        i_ce_n,
   input  wire logic        i_cle,
   input  wire logic        i_ale,
   input  wire logic        i_write_strobe_n,
   input  wire logic        i_read_strobe_n,
   input  wire logic        i_wp_n,
   input  wire logic [7:0]  i_shared_io_bus,
   output logic      [7:0]  o_shared_io_bus,
   output logic             o_rb_pull,
   output logic      [39:0] o_addr,
   output logic      [2:0]  o_addr_cnt
);
   logic [7:0]  mem_r [logic [30:0]];
   logic [7:0]  stage_r [logic [30:0]];
   logic [7:0]  io_r, out_r, cmd_r;
   logic [39:0] addr_r;
   logic [2:0]  acnt_r;
   logic [11:0] dcnt_r;
   logic [1:0]  lat_r;
   logic        we_r, re_r, fail_r, sts_r, ecc_r, init_r, bad;
   int          busy_r;
   logic [30:0] key;
   // row over column, one page register
   assign key = {addr_r[34:16], addr_r[11:0] + dcnt_r};
   // open drain pulled low while busy
   assign o_rb_pull = busy_r != 0;
   assign o_shared_io_bus = (!i_ce_n && !i_read_strobe_n) ? out_r : ~out_r;
   assign o_addr = addr_r;
   assign o_addr_cnt = acnt_r;
   // cache program refused with ECC on
   assign bad = !i_wp_n || (io_r == 8'h15 && ecc_r);
   initial begin
      {out_r, cmd_r, addr_r, acnt_r, dcnt_r, lat_r, fail_r, sts_r, ecc_r, init_r} = '0;
      {we_r, re_r} = 2'b11;
      busy_r = 0;
   end
   always @(posedge i_clock) begin
      we_r <= i_write_strobe_n;
      re_r <= i_read_strobe_n;
      io_r <= i_shared_io_bus;
      lat_r <= {i_cle, i_ale};
      if (busy_r != 0) busy_r <= busy_r - 1;
      // latch on rising write strobe, reset first
      if (!i_ce_n && !we_r && i_write_strobe_n) begin
         if (lat_r[1] && (init_r || io_r == 8'hFF)) begin
            cmd_r <= io_r;
            if (io_r != 8'h70) dcnt_r <= 12'h000;
            case (io_r)
               8'hFF: begin
                  init_r <= 1'b1;
                  busy_r <= SHORT_BUSY;
               end
               8'h00, 8'h80, 8'h60, 8'hEF: begin
                  acnt_r <= 3'h0;
                  fail_r <= 1'b0;
                  stage_r.delete();
               end
               // program and erase, refused when protected
               8'h10, 8'h15, 8'hD0: begin
                  fail_r <= bad;
                  if (!bad) begin
                     busy_r <= (io_r == 8'hD0) ? ERASE_BUSY : PROG_BUSY;
                     foreach (stage_r[k]) mem_r[k] = stage_r[k];
                  end
               end
               8'h30: busy_r <= SHORT_BUSY;
               8'h70: sts_r <= 1'b1;
               default: ;
            endcase
         end else if (lat_r[0]) begin
            addr_r <= {io_r, addr_r[39:8]};
            acnt_r <= acnt_r + 3'h1;
         end else if (!lat_r[1]) begin
            // ECC feature and one byte per strobe
            if (cmd_r == 8'hEF && dcnt_r == 12'h000 && addr_r[39:32] == 8'h90) ecc_r <= io_r[3];
            stage_r[key] = io_r;
            dcnt_r <= dcnt_r + 12'h001;
         end
      end
      // status byte first, then page data
      if (!i_ce_n && re_r && !i_read_strobe_n) begin
         out_r <= sts_r ? {i_wp_n, busy_r == 0, 5'h00, fail_r} : (mem_r.exists(key) ? mem_r[key] : 8'hFF);
      end
      if (!i_ce_n && !re_r && i_read_strobe_n) begin
         if (sts_r) sts_r <= 1'b0;
         else dcnt_r <= dcnt_r + 12'h001;
      end
   end
endmodule

// >>> tb_nand_host.sv
// Self-checking bench for the NAND host controller
`include "nand_host_cfg.svh"
module tb_nand_host;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, rst_n, req, big, wide, wp, wr_valid, ack, busy, err, ecc_on, rd_valid, wr_ready;
   logic        ce_n, cle, ale, we_n, re_n, wp_n, oe_n, rb_pull;
   logic [2:0]  op, acnt;
   logic [5:0]  page;
   logic [7:0]  wr_data, rd_data, status, io_out, dev_io;
   logic [11:0] col, len;
   logic [12:0] blk;
   logic [39:0] addr;
   logic [15:0] rnd;
   logic [7:0]  wr_q[$], exp_q[$], rd_q[$];
   int          err_count, comparisons, wr_cnt;
   wire  [7:0]  io_bus = !oe_n ? io_out : dev_io;
   wire         rb_n = rb_pull ? 1'b0 : 1'b1;
   nand_host #(.PROG_TIMEOUT(200), .ERASE_TIMEOUT(200)) u_dut (.i_clock(clock), .i_rst_n(rst_n),
      .i_req(req), .i_op(op), .i_column(col), .i_page(page), .i_block(blk), .i_big_die(big), .i_wide(wide),
      .i_wp_allow(wp), .i_len(len), .i_wr_valid(wr_valid), .o_wr_ready(wr_ready), .i_wr_data(wr_data),
      .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_ack(ack), .o_busy(busy), .o_err(err), .o_status(status),
      .o_ecc_on(ecc_on), .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_write_strobe_n(we_n),
      .o_read_strobe_n(re_n), .o_wp_n(wp_n), .o_io_out(io_out), .o_io_oe_n(oe_n), .i_io_in(io_bus),
      .i_ready_busy_n(rb_n));
   nand_die_model u_die (.i_clock(clock), .i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_write_strobe_n(we_n),
      .i_read_strobe_n(re_n), .i_wp_n(wp_n), .i_shared_io_bus(io_bus), .o_shared_io_bus(dev_io),
      .o_rb_pull(rb_pull), .o_addr(addr), .o_addr_cnt(acnt));
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [39:0] exp_addr(input logic [11:0] c, input logic [5:0] p, input logic [12:0] b,
                                            input logic bg);
      if (c[11]) c[10:6] = 5'h00;
      if (!bg) b[12] = 1'b0;
      return {5'h00, b, p, 4'h0, c};
   endfunction
   task automatic chk_val(input string name, input logic [39:0] exp, input logic [39:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", name, exp, got);
      end
   endtask
   task automatic end_of_test;
      if (err_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic do_op(input logic [2:0] code, input logic exp_err, input bit test_err);
      int n;
      op <= code;
      req <= 1'b1;
      @(posedge clock);
      req <= 1'b0;
      n = 0;
      while (ack !== 1'b1 && n < 30000) begin
         @(posedge clock);
         n++;
      end
      chk_val("ack", 40'h1, 40'(ack));
      if (test_err) chk_val("err", 40'(exp_err), 40'(err));
   endtask
   task automatic prog_read(input logic [11:0] c, input int n, input logic [2:0] pcode);
      rnd = lfsr_next(rnd);
      col <= c;
      page <= rnd[5:0];
      blk <= {rnd[15:6], rnd[2:0]};
      big <= rnd[9];
      len <= 12'(n);
      exp_q.delete();
      wr_cnt = 0;
      for (int i = 0; i < n; i++) begin
         rnd = lfsr_next(rnd);
         exp_q.push_back(rnd[7:0]);
         wr_q.push_back(rnd[7:0]);
      end
      repeat (20) @(posedge clock);
      if (n > `FIFO_DEPTH) chk_val("fifo_fill", 40'(`FIFO_DEPTH), 40'({wr_cnt, wr_ready}) >> 1);
      do_op(pcode, 1'b0, 1'b1);
      chk_val("addr", exp_addr(c, page, blk, big), addr);
      chk_val("addr_cnt", 40'h5, 40'(acnt));
      chk_val("prog_status", 40'hC0, 40'(status));
      chk_val("drain", 40'h1, 40'({wr_q.size() == 0 && wr_ready === 1'b1}));
      rd_q.delete();
      do_op(3'h1, 1'b0, 1'b1);
      chk_val("rd_count", 40'(n), 40'(rd_q.size()));
      foreach (exp_q[i]) chk_val("rd_data", 40'(exp_q[i]), 40'(rd_q[i]));
   endtask
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      repeat (60000) @(posedge clock);
      err_count++;
      end_of_test();
   end
   always @(posedge clock) begin
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      if (wr_valid && wr_ready === 1'b1) begin
         void'(wr_q.pop_front());
         wr_cnt++;
      end
      wr_valid <= wr_q.size() != 0;
      wr_data <= (wr_q.size() != 0) ? wr_q[0] : 8'h00;
   end
   initial begin
      {rst_n, req, big, wide, op, page, col, blk, len} = '0;
      wp = 1'b1;
      rnd = 16'h0041;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      do_op(3'h2, 1'b1, 1'b1);
      do_op(3'h0, 1'b0, 1'b1);
      do_op(3'h4, 1'b0, 1'b1);
      chk_val("status", 40'hC0, 40'(status));
      chk_val("ecc_off", 40'h0, 40'(ecc_on));
      prog_read(12'hFC0, 12, 3'h2);
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr_next(rnd);
         prog_read(rnd[11:0], 1 + int'(rnd[3:0]), (i == 2) ? 3'h6 : 3'h2);
      end
      rnd = lfsr_next(rnd);
      blk <= rnd[12:0] | 13'h0001;
      page <= 6'h00;
      do_op(3'h3, 1'b0, 1'b1);
      chk_val("erase_row", exp_addr(12'h000, page, blk, big) >> 16, {16'h0000, addr[39:16]});
      chk_val("erase_cnt", 40'h3, 40'(acnt));
      wp <= 1'b0;
      len <= 12'h001;
      wr_q.push_back(8'h5A);
      do_op(3'h2, 1'b1, 1'b1);
      chk_val("wp_status", 40'h41, 40'(status));
      wp <= 1'b1;
      do_op(3'h5, 1'b0, 1'b1);
      chk_val("ecc_on", 40'h1, 40'(ecc_on));
      do_op(3'h6, 1'b1, 1'b1);
      len <= 12'd2113;
      do_op(3'h1, 1'b1, 1'b1);
      wide <= 1'b1;
      len <= 12'd1057;
      do_op(3'h1, 1'b1, 1'b1);
      len <= 12'd1056;
      do_op(3'h1, 1'b0, 1'b1);
      end_of_test();
   end
endmodule
